// file: dv/tb.sv
// self-checking bench of the wake-up event controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rstn, psel, pen, pwr, go, lerr, evt_seen;
  logic [11:0] addr;
  logic [31:0] wdat, rd;
  logic [2:0] prot;
  logic [5:0] idx;
  wire logic [57:0] lv;
  wire logic rdy, err, irq, wake, cev;
  wire logic [31:0] rdat;
  wire logic [57:0] ilines;
  int bad_count = 0;
  int total_checks = 0;
  int lines[15] = '{0, 15, 16, 17, 20, 21, 24, 25, 30, 37, 38, 43, 47, 48, 53};
  wec_src_model wec_src_model_i (.clk_i(clk), .go_i(go), .idx_i(idx), .lvl_o(lv));
  wec_top wec_top_i (
    .MCLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(addr),
    .PWDATA_I(wdat), .PSTRB_I(4'hf), .PPROT_I(prot), .PREADY_O(rdy), .PSLVERR_O(err), .PRDATA_O(rdat),
    .GPIO_LINE_I(lv[15:0]), .SUPPLY_DET_I(lv[16]), .ANALOG_DET_I(1'b0), .RTC_NS_I(lv[17]), .RTC_S_I(lv[18]),
    .TAMPER_NS_I(lv[19]), .TAMPER_S_I(lv[20]), .TWI_WKUP_I(lv[23:21]), .I3C_WKUP_I(lv[24]),
    .SERIAL_WKUP_I(lv[30:25]), .LP_SERIAL_WKUP_I(lv[37]), .LP_TIMER_A_I(lv[38]), .LP_TIMER_B_I(lv[39]),
    .SPI_WKUP_I(lv[43:40]), .USB_FS_WKUP_I(lv[47]), .USB_PD_WKUP_I(lv[48]), .LP_TIMER_B_CH1_I(lv[49]),
    .TEMP_SENSOR_WKUP_I(lv[50]), .CEC_WKUP_I(lv[51]), .UVM_I(lv[53]), .IRQ_O(irq),
    .IRQ_LINES_O(ilines), .WAKE_REQ_O(wake), .CPU_EVENT_O(cev));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (cev === 1'b1) evt_seen <= 1'b1;
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] p);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; addr <= a; wdat <= d; prot <= p;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = rdat;
    lerr = err;
    psel <= 0;
    pen <= 0;
  endtask
  task fire(input int n, input logic [57:0] exp);
    idx <= n[5:0];
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (10) @(posedge clk);
    chk(ilines, exp);
  endtask
  task clr(input int n);
    apb(1, (n < 32) ? 12'h020 : 12'h024, 32'h1 << (n % 32), 3'h3);
  endtask
  task t_reset;
    apb(0, 12'h000, 0, 3'h3); chk(rd, 0);
    apb(0, 12'h024, 0, 3'h3); chk(rd, 0);
  endtask
  task t_edge;
    apb(1, 12'h000, 32'h8, 3'h3);
    fire(3, 58'h0);
    apb(0, 12'h020, 0, 3'h3); chk(rd, 32'h8);
    apb(1, 12'h010, 32'h8, 3'h3);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    clr(3);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    apb(1, 12'h018, 32'h8, 3'h3);
    evt_seen = 0;
    fire(3, 58'h8);
    chk(evt_seen, 1);
    chk(wake, 1);
    clr(3);
  endtask
  task t_map;
    apb(1, 12'h000, 32'hffffffff, 3'h3);
    apb(1, 12'h004, 32'hffffffff, 3'h3);
    apb(1, 12'h010, 32'hffffffff, 3'h3);
    apb(1, 12'h014, 32'hffffffff, 3'h3);
    foreach (lines[i]) begin
      fire(lines[i], 58'h1 << lines[i]);
      clr(lines[i]);
    end
    fire(33, 58'h0);
  endtask
  task t_fall;
    apb(1, 12'h000, 32'h0, 3'h3);
    apb(1, 12'h008, 32'h20, 3'h3);
    idx <= 6'h5;
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (4) @(posedge clk);
    apb(0, 12'h038, 0, 3'h3); chk(rd, 32'h20);
    chk(ilines, 58'h0);
    repeat (4) @(posedge clk);
    chk(ilines, 58'h20);
    clr(5);
    apb(1, 12'h000, 32'hffffffff, 3'h3);
  endtask
  task t_prot;
    apb(1, 12'h028, 32'h8, 3'h1);
    apb(0, 12'h000, 0, 3'h3); chk(rd, 32'hfffffff7);
    apb(1, 12'h000, 0, 3'h3);
    apb(0, 12'h000, 0, 3'h1); chk(rd, 32'h8);
    apb(1, 12'h000, 32'hffffffff, 3'h1);
    apb(1, 12'h030, 32'h10, 3'h1);
    apb(0, 12'h000, 0, 3'h0); chk(rd, 32'hffffffef);
    apb(1, 12'h000, 0, 3'h0);
    apb(0, 12'h000, 0, 3'h1); chk(rd, 32'h10);
  endtask
  task t_bad;
    apb(0, 12'h040, 0, 3'h1); chk({lerr, rd}, 33'h100000000);
    apb(1, 12'h002, 32'h1, 3'h1); chk(lerr, 1);
  endtask
  task final_report;
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    final_report;
  end
  initial begin
    rstn = 0; psel = 0; pen = 0; pwr = 0; addr = 0; wdat = 0; prot = 0; go = 0; idx = 0; evt_seen = 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    t_reset;
    t_edge;
    t_map;
    t_fall;
    t_prot;
    t_bad;
    final_report;
  end
endmodule // tb
`default_nettype wire

// file: dv/wec_properties.sv
// port assertions of the wake-up event controller
`timescale 1ns/1ps
`default_nettype none
module wec_properties (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [31:0] PRDATA_O,
  input wire logic IRQ_O,
  input wire logic [57:0] IRQ_LINES_O,
  input wire logic WAKE_REQ_O,
  input wire logic CPU_EVENT_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  wire acc = PSEL_I && PENABLE_I;
  wire wr = acc && PWRITE_I;
  property p_ready; acc |-> PREADY_O; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_unmapped; acc && (PADDR_I[1:0] != 2'h0 || PADDR_I > 12'h03c) |-> PSLVERR_O; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_err_setup; PSEL_I && !PENABLE_I |-> !PSLVERR_O; endproperty
  a_err_setup: assert property (p_err_setup) else $error("error outside access");
  property p_wr_data; wr |-> PRDATA_O == 32'h0; endproperty
  a_wr_data: assert property (p_wr_data) else $error("read data during write");
  property p_irq_or; IRQ_O == (|IRQ_LINES_O); endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not or of lines");
  property p_reserved; IRQ_LINES_O[36:31] == 6'h0; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved line fired");
  property p_irq_hold; IRQ_O && !wr && !$past(wr) |=> IRQ_O; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without write");
  property p_wake; IRQ_O || CPU_EVENT_O |-> WAKE_REQ_O; endproperty
  a_wake: assert property (p_wake) else $error("no wake with request");
  property p_rst; disable iff (1'b0) !RSTN_I |=> !IRQ_O && !WAKE_REQ_O && !CPU_EVENT_O; endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
  c_irq: cover property ($rose(IRQ_O));
  c_evt: cover property (CPU_EVENT_O);
  c_err: cover property (PSLVERR_O);
endmodule // wec_properties
bind wec_top wec_properties wec_properties_i (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .PRDATA_O(PRDATA_O), .IRQ_O(IRQ_O), .IRQ_LINES_O(IRQ_LINES_O),
  .WAKE_REQ_O(WAKE_REQ_O), .CPU_EVENT_O(CPU_EVENT_O));
`default_nettype wire

// file: dv/wec_src_model.sv
// event source model: raises one line for four cycles
`timescale 1ns/1ps
`default_nettype none
module wec_src_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [5:0] idx_i,
  output logic [57:0] lvl_o
);
  logic [2:0] cnt;
  initial begin
    lvl_o = 58'h0;
    cnt = 3'h0;
  end
  always @(posedge clk_i) begin
    if (go_i) begin
      lvl_o <= 58'h1 << idx_i;
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) lvl_o <= 58'h0;
    end
  end
endmodule // wec_src_model
`default_nettype wire

// file: verilog/none.v
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: verilog/wec_line_sync.v
// one event line: three-stage synchroniser, filtered level and edge pulses
`timescale 1ns/1ps
`default_nettype none
module wec_line_sync (
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // raw event from outside the clock domain
  input wire evt_i,
  // filtered level and one-cycle edge pulses
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg level_reg;
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= evt_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // change counts once the last two stages agree
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end
  assign level_o = level_reg;
  assign rise_o = (s2_reg == s3_reg) && s3_reg && !level_reg;
  assign fall_o = (s2_reg == s3_reg) && !s3_reg && level_reg;
endmodule // wec_line_sync
`default_nettype wire

// file: verilog/wec_regs.vh
// register map, reset values and line numbers of the wake-up event controller
// How it works
// - fifty-eight event lines, each individually configured
// - each line drives wake-up, interrupt and event
// - cpu event made after masking by generator
// - no pass-through lines; all go through triggers
// - secure line hides from non-secure access, except in sec_reg, which any read returns unfiltered
// - privileged line hides from unprivileged access, except in sec_reg, which all reads and secure unprivileged writes reach
// - all registers in one bus-reached block
// - edge trigger stage precedes masking and mux
// - lines zero to fifteen are pin lines
// - line sixteen is combined supply detectors
// - lines seventeen to twenty: clock, tamper events
// - lines 21-23 two-wire ports, 24 i3c
// - lines 25-30 serial ports one to six
// - lines 31-36 reserved, 37 low-power serial
// - any enabled line wakes system from stop
// - lines 38-39 timers, 40-43 spi ports
// - 47 usb, 48 power delivery, 49-51 and 53 mapped; 44-46, 52 and 54-57 stay zero
`ifndef WEC_REGS_VH
`define WEC_REGS_VH
`define WEC_LINES 58
`define WEC_HI_BITS 26
`define WEC_RISE_OFF 12'h000
`define WEC_FALL_OFF 12'h008
`define WEC_IMASK_OFF 12'h010
`define WEC_EMASK_OFF 12'h018
`define WEC_PEND_OFF 12'h020
`define WEC_SEC_OFF 12'h028
`define WEC_PRIV_OFF 12'h030
`define WEC_LEVEL_OFF 12'h038
`define WEC_HALF_BIT 2
`define WEC_RISE_RST 58'h0
`define WEC_FALL_RST 58'h0
`define WEC_IMASK_RST 58'h0
`define WEC_EMASK_RST 58'h0
`define WEC_PEND_RST 58'h0
`define WEC_SEC_RST 58'h0
`define WEC_PRIV_RST 58'h0
`define WEC_PROT_PRIV 0
`define WEC_PROT_NSEC 1
`define WEC_LN_SUPPLY 16
`define WEC_LN_RTC_NS 17
`define WEC_LN_RTC_S 18
`define WEC_LN_TAMPER_UNIT_NS 19
`define WEC_LN_TAMPER_UNIT_S 20
`define WEC_LN_TWI 21
`define WEC_LN_I3C 24
`define WEC_LN_SERIAL 25
`define WEC_LN_LPSERIAL 37
`define WEC_LN_LPTIM_A 38
`define WEC_LN_LPTIM_B 39
`define WEC_LN_SPI 40
`define WEC_LN_USB_FS 47
`define WEC_LN_USB_PD 48
`define WEC_LN_LPTIM_B_CH1 49
`define WEC_LN_TEMP 50
`define WEC_LN_CEC 51
`define WEC_LN_UVM 53
`endif

// file: verilog/wec_top.v
// wake-up and interrupt event controller with apb register block
`timescale 1ns/1ps
`default_nettype none
`include "wec_regs.vh"
module wec_top (
  // clock and reset
  input wire MCLK_I,
  input wire RSTN_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [3:0] PSTRB_I,
  input wire [2:0] PPROT_I,
  output wire PREADY_O,
  output wire PSLVERR_O,
  output wire [31:0] PRDATA_O,
  // event sources
  input wire [15:0] GPIO_LINE_I,
  input wire SUPPLY_DET_I,
  input wire ANALOG_DET_I,
  input wire RTC_NS_I,
  input wire RTC_S_I,
  input wire TAMPER_NS_I,
  input wire TAMPER_S_I,
  input wire [2:0] TWI_WKUP_I,
  input wire I3C_WKUP_I,
  input wire [5:0] SERIAL_WKUP_I,
  input wire LP_SERIAL_WKUP_I,
  input wire LP_TIMER_A_I,
  input wire LP_TIMER_B_I,
  input wire [3:0] SPI_WKUP_I,
  input wire USB_FS_WKUP_I,
  input wire USB_PD_WKUP_I,
  input wire LP_TIMER_B_CH1_I,
  input wire TEMP_SENSOR_WKUP_I,
  input wire CEC_WKUP_I,
  input wire UVM_I,
  // requests out
  output wire IRQ_O,
  output wire [57:0] IRQ_LINES_O,
  output wire WAKE_REQ_O,
  output wire CPU_EVENT_O
);
  // source map; reserved positions stay zero
  reg [57:0] src;
  always @* begin
    src = 58'h0;
    src[15:0] = GPIO_LINE_I;
    src[`WEC_LN_SUPPLY] = SUPPLY_DET_I | ANALOG_DET_I;
    src[`WEC_LN_RTC_NS] = RTC_NS_I;
    src[`WEC_LN_RTC_S] = RTC_S_I;
    src[`WEC_LN_TAMPER_UNIT_NS] = TAMPER_NS_I;
    src[`WEC_LN_TAMPER_UNIT_S] = TAMPER_S_I;
    src[`WEC_LN_TWI+2:`WEC_LN_TWI] = TWI_WKUP_I;
    src[`WEC_LN_I3C] = I3C_WKUP_I;
    src[`WEC_LN_SERIAL+5:`WEC_LN_SERIAL] = SERIAL_WKUP_I;
    src[`WEC_LN_LPSERIAL] = LP_SERIAL_WKUP_I;
    src[`WEC_LN_LPTIM_A] = LP_TIMER_A_I;
    src[`WEC_LN_LPTIM_B] = LP_TIMER_B_I;
    src[`WEC_LN_SPI+3:`WEC_LN_SPI] = SPI_WKUP_I;
    src[`WEC_LN_USB_FS] = USB_FS_WKUP_I;
    src[`WEC_LN_USB_PD] = USB_PD_WKUP_I;
    src[`WEC_LN_LPTIM_B_CH1] = LP_TIMER_B_CH1_I;
    src[`WEC_LN_TEMP] = TEMP_SENSOR_WKUP_I;
    src[`WEC_LN_CEC] = CEC_WKUP_I;
    src[`WEC_LN_UVM] = UVM_I;
  end

  // trigger stage, one per line
  wire [57:0] lvl;
  wire [57:0] rise_ev;
  wire [57:0] fall_ev;
  genvar gi;
  generate
    for (gi = 0; gi < `WEC_LINES; gi = gi + 1) begin : g_line
      wec_line_sync u_sync (
        .mclk_i(MCLK_I),
        .rstn_i(RSTN_I),
        .evt_i(src[gi]),
        .level_o(lvl[gi]),
        .rise_o(rise_ev[gi]),
        .fall_o(fall_ev[gi])
      );
    end
  endgenerate

  // configuration and status
  reg [57:0] rise_reg;
  reg [57:0] fall_reg;
  reg [57:0] imask_reg;
  reg [57:0] emask_reg;
  reg [57:0] pend_reg;
  reg [57:0] sec_reg;
  reg [57:0] priv_reg;
  reg [31:0] rdata_reg;
  reg slverr_reg;
  reg [57:0] irq_lines_reg;
  reg irq_reg;
  reg wake_reg;
  reg cpu_evt_reg;

  // lines this access may see: secure or privileged lines filtered
  function [57:0] acc_mask;
    input [57:0] sec;
    input [57:0] priv;
    input [2:0] prot;
    begin
      acc_mask = ~(sec & {58{prot[`WEC_PROT_NSEC]}}) &
                 ~(priv & {58{~prot[`WEC_PROT_PRIV]}});
    end
  endfunction

  // map one word onto the line vector
  function [57:0] to_lines;
    input hi;
    input [31:0] word;
    begin
      if (hi) begin
        to_lines = {word[`WEC_HI_BITS-1:0], 32'h0};
      end else begin
        to_lines = {26'h0, word};
      end
    end
  endfunction

  function [31:0] from_lines;
    input hi;
    input [57:0] v;
    begin
      if (hi) begin
        from_lines = {6'h0, v[57:32]};
      end else begin
        from_lines = v[31:0];
      end
    end
  endfunction

  // decode
  wire [11:0] word_off = {PADDR_I[11:3], 3'h0};
  wire hi_half = PADDR_I[`WEC_HALF_BIT];
  wire mapped = (PADDR_I[1:0] == 2'h0) && (word_off <= `WEC_LEVEL_OFF);
  wire wr_acc = PSEL_I && PENABLE_I && PWRITE_I && mapped;
  wire setup = PSEL_I && !PENABLE_I;
  wire nsec = PPROT_I[`WEC_PROT_NSEC];
  wire [57:0] am = acc_mask(sec_reg, priv_reg, PPROT_I);
  wire [31:0] strb_bits = {{8{PSTRB_I[3]}}, {8{PSTRB_I[2]}}, {8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
  wire [57:0] wmask = to_lines(hi_half, strb_bits);
  wire [57:0] wdat = to_lines(hi_half, PWDATA_I);
  wire [57:0] eff = wmask & am;

  // write selects
  wire wr_rise = wr_acc && (word_off == `WEC_RISE_OFF);
  wire wr_fall = wr_acc && (word_off == `WEC_FALL_OFF);
  wire wr_imask = wr_acc && (word_off == `WEC_IMASK_OFF);
  wire wr_emask = wr_acc && (word_off == `WEC_EMASK_OFF);
  wire wr_pend = wr_acc && (word_off == `WEC_PEND_OFF);
  wire wr_sec = wr_acc && (word_off == `WEC_SEC_OFF) && !nsec;
  wire wr_priv = wr_acc && (word_off == `WEC_PRIV_OFF);

  // detected edges after trigger selection
  wire [57:0] trig = (rise_ev & rise_reg) | (fall_ev & fall_reg);
  wire [57:0] pend_clr = wr_pend ? (wdat & eff) : 58'h0;
  wire [57:0] pend_next = (pend_reg & ~pend_clr) | trig;
  wire [57:0] irq_lines_next = pend_next & imask_reg;
  wire [57:0] evt_lines = trig & emask_reg;

  always @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      rise_reg <= `WEC_RISE_RST;
      fall_reg <= `WEC_FALL_RST;
      imask_reg <= `WEC_IMASK_RST;
      emask_reg <= `WEC_EMASK_RST;
      pend_reg <= `WEC_PEND_RST;
      sec_reg <= `WEC_SEC_RST;
      priv_reg <= `WEC_PRIV_RST;
    end else begin
      // blocked lines keep their bits, except in sec_reg, which is written under the strobes alone
      if (wr_rise) begin
        rise_reg <= (rise_reg & ~eff) | (wdat & eff);
      end
      if (wr_fall) begin
        fall_reg <= (fall_reg & ~eff) | (wdat & eff);
      end
      if (wr_imask) begin
        imask_reg <= (imask_reg & ~eff) | (wdat & eff);
      end
      if (wr_emask) begin
        emask_reg <= (emask_reg & ~eff) | (wdat & eff);
      end
      if (wr_sec) begin
        sec_reg <= (sec_reg & ~wmask) | (wdat & wmask);
      end
      if (wr_priv) begin
        priv_reg <= (priv_reg & ~eff) | (wdat & eff);
      end
      pend_reg <= pend_next;
    end
  end

  // read data captured in the setup cycle
  reg [57:0] rd_lines;
  always @* begin
    case (word_off)
      `WEC_RISE_OFF: rd_lines = rise_reg & am;
      `WEC_FALL_OFF: rd_lines = fall_reg & am;
      `WEC_IMASK_OFF: rd_lines = imask_reg & am;
      `WEC_EMASK_OFF: rd_lines = emask_reg & am;
      `WEC_PEND_OFF: rd_lines = pend_reg & am;
      `WEC_SEC_OFF: rd_lines = sec_reg;
      `WEC_PRIV_OFF: rd_lines = priv_reg & am;
      `WEC_LEVEL_OFF: rd_lines = lvl & am;
      default: rd_lines = 58'h0;
    endcase
  end

  always @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      rdata_reg <= 32'h0;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      rdata_reg <= (mapped && !PWRITE_I) ? from_lines(hi_half, rd_lines) : 32'h0;
      slverr_reg <= !mapped;
    end
  end

  // outputs toward the interrupt controller, power controller and cpu
  always @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      irq_lines_reg <= 58'h0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      cpu_evt_reg <= 1'b0;
    end else begin
      irq_lines_reg <= irq_lines_next;
      irq_reg <= |irq_lines_next;
      wake_reg <= (|irq_lines_next) | (|evt_lines);
      // event generator: one-cycle pulse for each cycle with any masked event
      cpu_evt_reg <= |evt_lines;
    end
  end

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && slverr_reg;
  assign PRDATA_O = rdata_reg;
  assign IRQ_LINES_O = irq_lines_reg;
  assign IRQ_O = irq_reg;
  assign WAKE_REQ_O = wake_reg;
  assign CPU_EVENT_O = cpu_evt_reg;
endmodule // wec_top
`default_nettype wire
